// File: hdl/cmp_filter.sv
// Purpose: synchronise and debounce one comparator result
// Assumes: input may be asynchronous to core_clk_i
// Notes:   output changes only after LEN equal samples
`timescale 1ns/10ps
module cmp_filter #(
	parameter int unsigned LEN       = 4,    // equal samples needed
	parameter logic        RESET_VAL = 1'b0  // value held during reset
) (
	input  wire logic core_clk_i,           // core clock
	input  wire logic arst_n_i,             // async reset, active low
	input  wire logic raw_i,                // raw comparator level
	output logic      filt_o                // filtered level
);
	//////////////////////////////////////////////////////////////////////
	logic       sync1_q;                    // first synchroniser stage
	logic       sync2_q;                    // second stage, safe to use
	logic [LEN-1:0] hist_q;                 // sample history
	// two flops; the first is read by the second only
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			sync1_q <= RESET_VAL;
			sync2_q <= RESET_VAL;
		end
		else
		begin
			sync1_q <= raw_i;
			sync2_q <= sync1_q;
		end
	end
	// shift history of settled samples
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			hist_q <= {LEN{RESET_VAL}};
		else
			hist_q <= {hist_q[LEN-2:0], sync2_q};
	end
	// move output only when all samples agree, rejecting glitches
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			filt_o <= RESET_VAL;
		else if (&hist_q)
			filt_o <= 1'b1;
		else if (~|hist_q)
			filt_o <= 1'b0;
	end
endmodule

// File: hdl/energy_manager_state_sequencer.sv
// Purpose: supervisory state machine of a dual-source energy manager
// Assumes: comparators report rail and storage against each threshold
// Notes:   analog converters act on the enable outputs
//
// Overview of operation
// - start in reset, leave on rail cold-start
// - sense storage, below overdischarge go overdischarge
// - overdischarge: evaluate, charge, rail from source
// - start: charge, load off, rail from storage
// - supply: charge, load on, ready flag set
// - overcharge in supply: sleep, harvest only when rail low
// - sleep: recharge rail, brief top-up supply
// - supply undervoltage waits critical delay first
// - overdischarge: load off, flag low, source rail
// - rail below reset threshold forces reset
// - reset state: storage node high impedance
// - external charger stops below overcharge margin
// - tracking holds source at open-circuit ratio in overdischarge, start and supply, not in sleep
// - shipping mode blocks charge and discharge
`timescale 1ns/10ps
module energy_manager_state_sequencer
	import energy_seq_pkg::*;
#(
	parameter int unsigned CRIT_CYC  = energy_seq_pkg::CRIT_DELAY_CYC, // delay
	parameter int unsigned TOPUP_CYC = energy_seq_pkg::TOPUP_HOLD_CYC, // hold
	parameter int unsigned FILT      = energy_seq_pkg::FILT_LEN // filter depth
) (
	input  wire logic core_clk_i,        // core clock, 125 MHz
	input  wire logic arst_n_i,          // async reset, active low
	input  wire logic rail_cs_ok_i,      // rail above cold-start threshold
	input  wire logic rail_rst_ok_i,     // rail above reset threshold
	input  wire logic rail_low_i,        // rail needs recharge
	input  wire logic sto_overdischarge_state_ok_i,    // storage above overdischarge
	input  wire logic sto_chrdy_ok_i,    // storage above charge-ready
	input  wire logic sto_ovch_i,        // storage at overcharge
	input  wire logic sto_ovch_mgn_i,    // storage within charger margin
	input  wire logic sto_topup_i,       // storage dropped, top-up needed
	input  wire logic ext_chg_present_i, // external charger input present
	input  wire logic mpp_mode_i,        // max_power_tracking selected
	input  wire logic ship_mode_i,       // shipping mode selected
	output logic      harvest_en_o,      // boost harvesting enabled
	output logic      load_en_o,         // regulated load output on
	output logic      storage_ready_flag_o, // storage ready status
	output logic      rail_from_src_o,   // rail fed from source
	output logic      rail_from_sto_o,   // rail fed from storage
	output logic      sto_hiz_o,         // storage node high impedance
	output logic      voc_eval_o,        // open-circuit evaluation pulse
	output logic      mpp_reg_en_o,      // ratio regulation active
	output logic [6:0] mpp_ratio_o,      // ratio in percent
	output logic      ext_chg_en_o,      // external charger enabled
	output logic [2:0] state_o           // current state code
);
	//////////////////////////////////////////////////////////////////////
	// filtered comparator levels
	logic       cs_f;                    // cold-start reached
	logic       rst_f;                   // rail above reset
	logic       rlow_f;                  // rail low
	logic       overdischarge_state_f;                 // storage above overdischarge
	logic       chrdy_f;                 // storage above charge-ready
	logic       ovch_f;                  // storage at overcharge
	logic       mgn_f;                   // within charger margin
	logic       topup_f;                 // storage needs top-up
	localparam int unsigned NCMP = 8;    // comparator count
	logic [NCMP-1:0] raw_w;              // raw comparator vector
	logic [NCMP-1:0] flt_w;              // filtered vector
	logic [NCMP-1:0] rst_val_w;          // reset values (all low)

	assign raw_w = {rail_cs_ok_i, rail_rst_ok_i, rail_low_i, sto_overdischarge_state_ok_i,
		sto_chrdy_ok_i, sto_ovch_i, sto_ovch_mgn_i, sto_topup_i};
	assign rst_val_w = '0;
	assign {cs_f, rst_f, rlow_f, overdischarge_state_f, chrdy_f, ovch_f, mgn_f, topup_f}
		= flt_w;

	// one filter per comparator; noisy analog edges must not chatter the fsm
	genvar gi;
	generate
		for (gi = 0; gi < NCMP; gi++)
		begin : g_flt
			cmp_filter #(
				.LEN       (FILT),
				.RESET_VAL (1'b0)
			) u_flt (
				.core_clk_i (core_clk_i),
				.arst_n_i   (arst_n_i),
				.raw_i      (raw_w[gi]),
				.filt_o     (flt_w[gi])
			);
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////
	// state and timers
	seq_state_t   state_q;               // current state
	seq_state_t   state_d;               // next state
	logic [CNT_W-1:0] crit_q;            // critical delay counter
	logic [CNT_W-1:0] topup_q;           // sleep top-up hold counter
	logic         in_topup_q;            // supply entered from sleep
	logic         crit_done;             // critical delay elapsed
	logic         topup_done;            // top-up hold elapsed

	assign crit_done  = (crit_q >= CNT_W'(CRIT_CYC - 1));
	assign topup_done = (topup_q >= CNT_W'(TOPUP_CYC - 1));

	// next-state decode
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			ST_RESET:
				if (cs_f)
					state_d = ST_SENSE;
			ST_SENSE:
				if (!overdischarge_state_f)
					state_d = ST_OVERDISCHARGE_STATE;
				else if (chrdy_f)
					state_d = ST_SUPPLY;
				else
					state_d = ST_START;
			ST_OVERDISCHARGE_STATE:
				if (overdischarge_state_f)
					state_d = ST_START;
			ST_START:
				if (chrdy_f)
					state_d = ST_SUPPLY;
				else if (!overdischarge_state_f)
					state_d = ST_OVERDISCHARGE_STATE;
			ST_SUPPLY:
				if (!overdischarge_state_f && crit_done)
					state_d = ST_OVERDISCHARGE_STATE;
				else if (ovch_f)
					state_d = ST_SLEEP;
				else if (in_topup_q && topup_done)
					state_d = ST_SLEEP;
			ST_SLEEP:
				if (topup_f && !ovch_f)
					state_d = ST_SUPPLY;
		endcase
		// rail loss overrides every other move except the one out of reset
		if (!rst_f && state_q != ST_RESET)
			state_d = ST_RESET;
	end

	// state register
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			state_q <= ST_RESET;
		else
			state_q <= state_d;
	end

	// critical delay: counts while storage stays under overdischarge in supply
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			crit_q <= '0;
		else if (state_q == ST_SUPPLY && !overdischarge_state_f && !crit_done)
			crit_q <= crit_q + CNT_W'(1);
		else if (state_q != ST_SUPPLY || overdischarge_state_f)
			crit_q <= '0;
	end

	// top-up marker: supply visit that came from sleep is brief
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			in_topup_q <= 1'b0;
		else if (state_q == ST_SLEEP && state_d == ST_SUPPLY)
			in_topup_q <= 1'b1;
		else if (state_q != ST_SUPPLY)
			in_topup_q <= 1'b0;
	end

	// top-up hold counter; limits the visit so storage is not overfilled
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			topup_q <= '0;
		else if (in_topup_q && state_q == ST_SUPPLY && !topup_done)
			topup_q <= topup_q + CNT_W'(1);
		else if (!in_topup_q)
			topup_q <= '0;
	end

	//////////////////////////////////////////////////////////////////////
	// output gating, registered so outputs never glitch on state decode
	logic in_charge;                         // charging state
	assign in_charge = (state_d == ST_OVERDISCHARGE_STATE) || (state_d == ST_START)
		|| (state_d == ST_SUPPLY);

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			harvest_en_o         <= 1'b0;
			load_en_o            <= 1'b0;
			storage_ready_flag_o <= 1'b0;
			rail_from_src_o      <= 1'b1;
			rail_from_sto_o      <= 1'b0;
			sto_hiz_o            <= 1'b1;
		end
		else
		begin
			// shipping mode forbids both directions of storage current
			harvest_en_o <= (in_charge || (state_d == ST_SLEEP && rlow_f))
				&& !ship_mode_i;
			load_en_o <= (state_d == ST_SUPPLY) && !ship_mode_i;
			storage_ready_flag_o <= (state_d == ST_SUPPLY);
			rail_from_src_o <= (state_d == ST_RESET)
				|| (state_d == ST_SENSE) || (state_d == ST_OVERDISCHARGE_STATE)
				|| (state_d == ST_SLEEP && rlow_f);
			rail_from_sto_o <= (state_d == ST_START)
				|| (state_d == ST_SUPPLY)
				|| (state_d == ST_SLEEP && !rlow_f);
			sto_hiz_o <= (state_d == ST_RESET) || ship_mode_i;
		end
	end

	// open-circuit evaluation pulse on entry to overdischarge
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			voc_eval_o <= 1'b0;
		else
			voc_eval_o <= (state_d == ST_OVERDISCHARGE_STATE) && (state_q != ST_OVERDISCHARGE_STATE)
				&& mpp_mode_i;
	end

	// ratio regulation across the charging states
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			mpp_reg_en_o <= 1'b0;
			mpp_ratio_o  <= MPP_RATIO_RESET;
		end
		else
		begin
			mpp_reg_en_o <= mpp_mode_i && in_charge && !ship_mode_i;
			mpp_ratio_o  <= 7'(MPP_RATIO_PCT);
		end
	end

	// external charger: stops inside the margin below overcharge
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			ext_chg_en_o <= 1'b0;
		else
			ext_chg_en_o <= ext_chg_present_i && !mgn_f && !ovch_f
				&& !ship_mode_i && state_d != ST_RESET;
	end

	// state code for observation
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			state_o <= 3'h0;
		else
			state_o <= state_d;
	end
endmodule

// File: hdl/energy_seq_pkg.sv
// Purpose: shared constants for the energy manager state sequencer
// Assumes: comparator results arrive as single-bit levels
// Notes:   times are given in their own unit, counts derived from the clock
package energy_seq_pkg;
	localparam int unsigned CLK_PERIOD_NS      = 8;       // core clock period
	localparam int unsigned CRIT_DELAY_US      = 1000;    // critical discharge delay
	localparam int unsigned CRIT_DELAY_CYC     =
		(CRIT_DELAY_US * 1000) / CLK_PERIOD_NS;             // longest time, round down
	localparam int unsigned FILT_LEN           = 4;       // filter depth, samples
	localparam int unsigned TOPUP_HOLD_US      = 10;      // sleep top-up hold time
	localparam int unsigned TOPUP_HOLD_CYC     =
		(TOPUP_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS; // round up
	localparam int unsigned CHG_MARGIN_MV      = 100;     // charger stop margin
	localparam int unsigned MPP_RATIO_PCT      = 75;      // regulation ratio
	localparam int unsigned CNT_W              = 24;      // delay counter width
	localparam logic [6:0]  MPP_RATIO_RESET    = 7'h4b;   // 75 percent
	typedef enum logic [2:0] {
		ST_RESET,
		ST_SENSE,
		ST_OVERDISCHARGE_STATE,
		ST_START,
		ST_SUPPLY,
		ST_SLEEP
	} seq_state_t;
endpackage

// File: testbench/energy_seq_monitor.sv
// Purpose: concurrent checks on the sequencer ports
// Assumes: state codes from the shared package
// Notes:   critical window counted on the raw storage comparator
`timescale 1ns/10ps
module energy_seq_monitor
	import energy_seq_pkg::*;
#(
	parameter int unsigned CRIT_CYC = 20 // critical delay, cycles
) (
	input wire logic       core_clk_i,           // core clock
	input wire logic       arst_n_i,             // async reset
	input wire logic       rail_rst_ok_i,        // rail above reset
	input wire logic       sto_overdischarge_state_ok_i,       // storage ok
	input wire logic       mpp_mode_i,           // tracking mode
	input wire logic       ship_mode_i,          // shipping mode
	input wire logic       harvest_en_o,         // harvesting
	input wire logic       load_en_o,            // load output
	input wire logic       storage_ready_flag_o, // ready flag
	input wire logic       rail_from_src_o,      // rail from source
	input wire logic       rail_from_sto_o,      // rail from storage
	input wire logic       sto_hiz_o,            // storage hi-z
	input wire logic       voc_eval_o,           // evaluation pulse
	input wire logic [6:0] mpp_ratio_o,          // tracking ratio
	input wire logic [2:0] state_o               // state code
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	int unsigned low_cnt_q; // supply cycles with storage low
	////////////////////////////////////////////////////////////////////
	// the filter adds latency, so the raw count only bounds from below
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			low_cnt_q <= 0;
		else if (state_o == ST_SUPPLY && !sto_overdischarge_state_ok_i)
			low_cnt_q <= low_cnt_q + 1;
		else
			low_cnt_q <= 0;
	end
	sequence overdischarge_state_entry; $changed(state_o) && state_o == ST_OVERDISCHARGE_STATE; endsequence
	sequence voc_pulse; voc_eval_o ##1 !voc_eval_o; endsequence
	ready_in_supply_a: assert property (storage_ready_flag_o == (state_o == ST_SUPPLY))
		else $error("ready flag off its state");
	reset_hiz_a: assert property (state_o == ST_RESET |-> sto_hiz_o)
		else $error("storage driven in reset");
	overdischarge_state_outputs_a: assert property (state_o == ST_OVERDISCHARGE_STATE |-> !load_en_o && rail_from_src_o)
		else $error("overdischarge outputs wrong");
	start_outputs_a: assert property (state_o == ST_START |-> !load_en_o && rail_from_sto_o)
		else $error("start outputs wrong");
	supply_load_a: assert property (state_o == ST_SUPPLY && !ship_mode_i && !$past(ship_mode_i) |-> load_en_o)
		else $error("load off in supply");
	sleep_harvest_a: assert property (state_o == ST_SLEEP && !rail_from_src_o |-> !harvest_en_o)
		else $error("harvesting in sleep");
	rail_loss_a: assert property (!rail_rst_ok_i [*6] |-> ##[0:6] state_o == ST_RESET)
		else $error("no reset on rail loss");
	voc_entry_a: assert property (overdischarge_state_entry ##0 mpp_mode_i |-> voc_pulse)
		else $error("no evaluation pulse");
	crit_min_a: assert property (state_o == ST_OVERDISCHARGE_STATE && $past(state_o) == ST_SUPPLY |-> $past(low_cnt_q) >= CRIT_CYC)
		else $error("left supply too early");
	ratio_fixed_a: assert property (mpp_ratio_o == MPP_RATIO_RESET)
		else $error("ratio wrong");
endmodule

// File: testbench/seq_cmp_model.sv
// Purpose: comparator bank on the far side of the sequencer
// Assumes: bench sets storage and rail voltages in millivolts
// Notes:   thresholds are plain defaults of our own
`timescale 1ns/10ps
module seq_cmp_model
	import energy_seq_pkg::*;
#(
	parameter int CS_MV    = 2600, // rail cold-start level
	parameter int RST_MV   = 2300, // rail reset level
	parameter int LOW_MV   = 2500, // rail recharge level
	parameter int OVERDISCHARGE_STATE_MV = 3000, // overdischarge_threshold
	parameter int CHRDY_MV = 3300, // charge_ready_threshold
	parameter int OVCH_MV  = 4120, // overcharge_threshold
	parameter int TOPUP_MV = 4000  // top-up request level
) (
	input  wire logic [15:0] sto_mv_i,  // storage voltage
	input  wire logic [15:0] internal_supply_rail_mv_i, // rail voltage
	output logic             cs_ok_o,   // rail cold-started
	output logic             rst_ok_o,  // rail above reset
	output logic             low_o,     // rail wants recharge
	output logic             ovd_ok_o,  // storage above overdischarge
	output logic             rdy_ok_o,  // storage above charge-ready
	output logic             ovch_o,    // storage at overcharge
	output logic             mgn_o,     // storage inside charger margin
	output logic             topup_o    // storage dropped in sleep
);
	int storage_node; // storage as a signed count
	int vnt; // rail as a signed count
	assign storage_node = int'(sto_mv_i);
	assign vnt = int'(internal_supply_rail_mv_i);
	// levels follow at once; bouncing is the sequencer's job to filter
	assign cs_ok_o  = vnt >= CS_MV;
	assign rst_ok_o = vnt >= RST_MV;
	assign low_o    = vnt < LOW_MV;
	assign ovd_ok_o = storage_node >= OVERDISCHARGE_STATE_MV;
	assign rdy_ok_o = storage_node >= CHRDY_MV;
	assign ovch_o   = storage_node >= OVCH_MV;
	assign mgn_o    = storage_node >= OVCH_MV - int'(CHG_MARGIN_MV);
	assign topup_o  = storage_node < TOPUP_MV;
endmodule

// File: testbench/tb.sv
// Purpose: self-checking bench for the state sequencer
// Assumes: comparator model on the far side, short delay counts
// Notes:   driver queues expected states, a watcher pops them
`timescale 1ns/10ps
module tb;
	import energy_seq_pkg::*;
	localparam int CRIT = 20; // shortened critical delay
	logic core_clk_i = 1'b0, arst_n_i = 1'b0;
	logic mpp_mode_i = 1'b1, ship_mode_i = 1'b0, ext_chg_present_i = 1'b0;
	logic [15:0] sto_mv = 16'h0af0, internal_supply_rail_mv = 16'h0000; // far-side millivolts
	logic [31:0] rnd = 32'hfbc73b92; // xorshift state
	logic [2:0] exp_q[$], cur = 3'h0, last = 3'h0, state_o;
	int miscompares = 0, checks_done = 0, n;
	wire cs, rst, low, ovd, rdy, och, mgn, top; // comparator levels
	logic harvest_en_o, load_en_o, storage_ready_flag_o, rail_from_src_o;
	logic rail_from_sto_o, sto_hiz_o, voc_eval_o, ext_chg_en_o, mpp_reg_en_o;
	logic [6:0] mpp_ratio_o;
	energy_manager_state_sequencer #(.CRIT_CYC(CRIT), .TOPUP_CYC(10),
		.FILT(4)) dut (.core_clk_i, .arst_n_i, .rail_cs_ok_i(cs),
		.rail_rst_ok_i(rst), .rail_low_i(low), .sto_overdischarge_state_ok_i(ovd),
		.sto_chrdy_ok_i(rdy), .sto_ovch_i(och), .sto_ovch_mgn_i(mgn),
		.sto_topup_i(top), .ext_chg_present_i, .mpp_mode_i, .ship_mode_i,
		.harvest_en_o, .load_en_o, .storage_ready_flag_o, .rail_from_src_o,
		.rail_from_sto_o, .sto_hiz_o, .voc_eval_o, .mpp_reg_en_o,
		.mpp_ratio_o, .ext_chg_en_o, .state_o);
	seq_cmp_model cmp (.sto_mv_i(sto_mv), .internal_supply_rail_mv_i(internal_supply_rail_mv), .cs_ok_o(cs),
		.rst_ok_o(rst), .low_o(low), .ovd_ok_o(ovd), .rdy_ok_o(rdy),
		.ovch_o(och), .mgn_o(mgn), .topup_o(top));
	always #4 core_clk_i = ~core_clk_i; // 125 MHz
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] r;
		r = v ^ (v << 13);
		r = r ^ (r >> 17);
		return r ^ (r << 5);
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want)
		begin
			miscompares++;
			$display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// inputs move 1 ns after the edge so sampling never races them
	task automatic drive(input int s, input int v);
		@(posedge core_clk_i);
		#1;
		sto_mv = 16'(s);
		internal_supply_rail_mv = 16'(v);
		rnd = xs(rnd);
		ext_chg_present_i = rnd[0];
	endtask
	// bounded wait until every queued state has been seen
	task automatic wait_q(input int lim, output int k);
		k = 0;
		while (exp_q.size() != 0 && k < lim)
		begin
			@(posedge core_clk_i);
			#1;
			k++;
		end
		chk(32'(exp_q.size()), 32'h0);
	endtask
	// after filter latency, every level output follows from the state
	task automatic levels();
		logic sl, chg;
		repeat (12) @(posedge core_clk_i);
		#1;
		sl = cur == ST_SLEEP;
		chg = cur inside {ST_OVERDISCHARGE_STATE, ST_START, ST_SUPPLY};
		chk(32'({load_en_o, storage_ready_flag_o}), 32'({cur == ST_SUPPLY && !ship_mode_i, cur == ST_SUPPLY}));
		chk(32'({rail_from_src_o, rail_from_sto_o}), 32'({cur inside {ST_RESET, ST_SENSE, ST_OVERDISCHARGE_STATE} || sl && low, cur inside {ST_START, ST_SUPPLY} || sl && !low}));
		chk(32'(harvest_en_o), 32'(!ship_mode_i && (chg || sl && low)));
		chk(32'(sto_hiz_o), 32'(cur == ST_RESET || ship_mode_i));
		chk(32'(mpp_reg_en_o), 32'(mpp_mode_i && chg && !ship_mode_i));
		chk(32'(ext_chg_en_o), 32'(ext_chg_present_i && !mgn && !och && !ship_mode_i && cur != ST_RESET));
	endtask
	// watcher: each state change takes the oldest queued expectation;
	// it looks on the falling edge so the state code has settled
	always @(negedge core_clk_i)
	begin
		if (state_o !== last)
		begin
			if (exp_q.size() == 0)
				chk(32'(state_o), 32'h7);
			else
			begin
				cur = exp_q.pop_front();
				chk(32'(state_o), 32'(cur));
			end
		end
		last = state_o;
	end
	initial
	begin
		repeat (5) @(posedge core_clk_i);
		#1;
		arst_n_i = 1'b1;
		levels();
		exp_q = '{ST_SENSE, ST_OVERDISCHARGE_STATE};
		drive(2800, 3000);
		wait_q(200, n);
		levels();
		exp_q = '{ST_START};
		drive(3100, 3000);
		wait_q(200, n);
		levels();
		exp_q = '{ST_SUPPLY};
		drive(3400, 3000);
		wait_q(200, n);
		levels();
		exp_q = '{ST_SLEEP};
		drive(4150, rnd[1] ? 2400 : 3000);
		wait_q(200, n);
		levels();
		exp_q = '{ST_SUPPLY};
		drive(3900, 3000);
		wait_q(200, n);
		exp_q = '{ST_SLEEP};
		drive(4050, 3000);
		wait_q(200, n);
		levels();
		exp_q = '{ST_RESET};
		drive(4050, 0);
		wait_q(200, n);
		levels();
		exp_q = '{ST_SENSE, ST_SUPPLY};
		drive(3400, 3000);
		wait_q(200, n);
		drive(3400, 0);
		drive(3400, 3000);
		ship_mode_i = 1'b1;
		levels();
		ship_mode_i = 1'b0;
		exp_q = '{ST_OVERDISCHARGE_STATE};
		drive(2800, 3000);
		wait_q(400, n);
		chk(32'(n >= CRIT), 32'h1);
		levels();
		exp_q = '{ST_RESET};
		drive(2800, 0);
		wait_q(200, n);
		levels();
		summarize();
	end
	// the sequence needs under a thousand cycles; allow five times that
	initial
	begin
		#(8 * 5000);
		miscompares++;
		summarize();
	end
endmodule
bind energy_manager_state_sequencer energy_seq_monitor #(.CRIT_CYC(CRIT_CYC))
	mon (.core_clk_i, .arst_n_i, .rail_rst_ok_i, .sto_overdischarge_state_ok_i, .mpp_mode_i,
	.ship_mode_i, .harvest_en_o, .load_en_o, .storage_ready_flag_o,
	.rail_from_src_o, .rail_from_sto_o, .sto_hiz_o, .voc_eval_o,
	.mpp_ratio_o, .state_o);
